// File: logic/otp_osc_map.svh
`ifndef OTP_OSC_MAP_SVH
`define OTP_OSC_MAP_SVH

// Register word indices (osc_trim_reg index chosen locally)
`define OTP_IDX_TRIM         12'hf9b
`define OTP_IDX_CTRL2        12'hf87
`define OTP_IDX_MODE         12'hf90
`define OTP_IDX_STATUS       12'hf94

// Bus byte addresses: four times the word index, so every register is word aligned
`define OTP_ADDR_W           14
`define OTP_ADDR_TRIM        {`OTP_IDX_TRIM, 2'h0}
`define OTP_ADDR_CTRL2       {`OTP_IDX_CTRL2, 2'h0}
`define OTP_ADDR_MODE        {`OTP_IDX_MODE, 2'h0}
`define OTP_ADDR_STATUS      {`OTP_IDX_STATUS, 2'h0}

// osc_trim_reg fields
`define OTP_TRIM_SRC_BIT     7
`define OTP_TRIM_FREQ_MULTIPLIER_ENABLE_BIT   6
`define OTP_TRIM_LSB         0
`define OTP_TRIM_MSB         5
`define OTP_TRIM_RESET       8'h00

// oscillator_control_two fields
`define OTP_C2_RUN_BIT       6
`define OTP_C2_DRV_BIT       4
`define OTP_C2_GO_BIT        3
`define OTP_C2_RSV_BIT       2
`define OTP_C2_RESET         8'h14
`define OTP_C2_WMASK         8'h1c

// Mode register fields
`define OTP_MODE_LSB         0
`define OTP_MODE_MSB         1
`define OTP_MODE_RESET       2'h0

// Status register fields
`define OTP_ST_PLLON_BIT     0
`define OTP_ST_LOCK_BIT      1
`define OTP_ST_ONPLL_BIT     2
`define OTP_ST_SOSCON_BIT    3
`define OTP_ST_SETTLE_BIT    4

// Timing
`define OTP_CLK_MHZ          125
`define OTP_SETTLE_NS        1000
`define OTP_SETTLE_CYC       ((`OTP_SETTLE_NS * `OTP_CLK_MHZ) / 1000)
`define OTP_SETTLE_W         8
`define OTP_NOMINAL_KHZ      8000
`define OTP_SLOW_KHZ         31

// AXI responses
`define OTP_RESP_OKAY        2'h0
`define OTP_RESP_SLVERR      2'h2

`endif

// File: logic/otp_pkg.sv
package otp_pkg;

    // Oscillator modes: only the multiplied mode may use the PLL
    typedef enum logic [1:0] {
        OTP_MODE_FAST     = 2'h0,
        OTP_MODE_SLOW     = 2'h1,
        OTP_MODE_MULT     = 2'h2,
        OTP_MODE_SECOND   = 2'h3
    } otp_mode_t;

    // Core clock switch sequencer
    typedef enum logic [1:0] {
        OTP_CLK_BASE,
        OTP_CLK_WAIT_LOCK,
        OTP_CLK_ON_PLL
    } otp_clk_state_t;

    // Analog control bundle toward the oscillator block
    typedef struct packed {
        logic [5:0] fast_trim;
        logic       low_freq_source_select;
        logic       pll_enable;
        logic       core_on_pll;
        logic       secondary_run;
    } otp_osc_ctrl_t;

endpackage : otp_pkg

// File: logic/otp_osc_ctrl.sv
// Summary of operation
// - Trim write starts oscillator retune, about 1us
// - Core keeps running; no completion flag
// - Source select picks 31 kHz oscillator
// - PLL enabled only in multiplied mode
// - No immediate switch while PLL locks
// - Switch to PLL automatically on lock
// - Nominal untrimmed frequency is 8.0 MHz
// - Trim never touches slow RC
// - Higher trim value gives higher frequency
// - Force-on keeps secondary oscillator running, except with a digital clock input
`include "otp_osc_map.svh"

module otp_osc_ctrl (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write address
    input  wire logic [`OTP_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [`OTP_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Oscillator block status
    input  wire logic                  pll_locked,
    input  wire logic                  secondary_request,
    input  wire logic                  secondary_digital_in,
    // Oscillator block control
    output otp_pkg::otp_osc_ctrl_t     osc_ctrl,
    output logic [`OTP_TRIM_MSB:0]     slow_rc_trim,
    output logic [13:0]                fast_osc_khz
);

    // Register storage
    logic [7:0]                   trim_reg;
    logic [7:0]                   ctrl2_reg;
    otp_pkg::otp_mode_t           mode_reg;
    otp_pkg::otp_clk_state_t      clk_state;
    otp_pkg::otp_clk_state_t      next_clk_state;
    logic [`OTP_SETTLE_W-1:0]     settle_cnt;
    logic                         aw_held;
    logic                         w_held;
    logic [`OTP_ADDR_W-1:0]       aw_addr;
    logic [31:0]                  w_data;
    logic                         w_lane0;

    // Write decode happens once both halves are held
    // Exact byte compare: only the aligned word of each register answers
    wire        wr_fire   = aw_held && w_held && !s_axi_bvalid;
    wire        wr_lane   = wr_fire && w_lane0;
    wire        wr_trim   = wr_lane && (aw_addr == `OTP_ADDR_TRIM);
    wire        wr_ctrl2  = wr_lane && (aw_addr == `OTP_ADDR_CTRL2);
    wire        wr_mode   = wr_lane && (aw_addr == `OTP_ADDR_MODE);
    wire        wr_known  = is_mapped(aw_addr);
    wire        rd_fire   = s_axi_arvalid && s_axi_arready;

    // Mapped address check shared by both channels
    function automatic logic is_mapped(input logic [`OTP_ADDR_W-1:0] a);
        is_mapped = (a == `OTP_ADDR_TRIM) || (a == `OTP_ADDR_CTRL2) ||
                    (a == `OTP_ADDR_MODE) || (a == `OTP_ADDR_STATUS);
    endfunction : is_mapped

    // Handshake outputs: accept each channel while empty
    // A held half blocks a second offer until the response is out
    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;

    // Write channel capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= 32'h0000_0000;
            w_lane0 <= 1'b0;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held  <= 1'b1;
                w_data  <= s_axi_wdata;
                w_lane0 <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response one cycle after both halves meet
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `OTP_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? `OTP_RESP_OKAY : `OTP_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_reg <= `OTP_TRIM_RESET;
        end else if (wr_trim) begin
            trim_reg <= w_data[7:0];
        end
    end

    // Force-on, drive and reserved bits writable; run flag not
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl2_reg <= `OTP_C2_RESET;
        end else if (wr_ctrl2) begin
            ctrl2_reg <= (ctrl2_reg & ~`OTP_C2_WMASK) | (w_data[7:0] & `OTP_C2_WMASK);
        end
    end

    // Oscillator mode selection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= otp_pkg::otp_mode_t'(`OTP_MODE_RESET);
        end else if (wr_mode) begin
            mode_reg <= otp_pkg::otp_mode_t'(w_data[`OTP_MODE_MSB:`OTP_MODE_LSB]);
        end
    end

    wire pll_allowed = (mode_reg == otp_pkg::OTP_MODE_MULT);
    wire pll_request = pll_allowed && trim_reg[`OTP_TRIM_FREQ_MULTIPLIER_ENABLE_BIT];

    always_comb begin
        next_clk_state = clk_state;
        case (clk_state)
            otp_pkg::OTP_CLK_BASE: begin
                if (pll_request) begin
                    next_clk_state = otp_pkg::OTP_CLK_WAIT_LOCK;
                end
            end
            otp_pkg::OTP_CLK_WAIT_LOCK: begin
                if (!pll_request) begin
                    next_clk_state = otp_pkg::OTP_CLK_BASE;
                end else if (pll_locked) begin
                    next_clk_state = otp_pkg::OTP_CLK_ON_PLL;
                end
            end
            otp_pkg::OTP_CLK_ON_PLL: begin
                if (!pll_request) begin
                    next_clk_state = otp_pkg::OTP_CLK_BASE;
                end
            end
            default: begin
                next_clk_state = otp_pkg::OTP_CLK_BASE;
            end
        endcase
    end

    // Clock switch state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_state <= otp_pkg::OTP_CLK_BASE;
        end else begin
            clk_state <= next_clk_state;
        end
    end

    // Settling window after a trim write, internal only
    // Core is never stalled by it
    // Kept internal on purpose: software gets no completion flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_cnt <= '0;
        end else if (wr_trim) begin
            settle_cnt <= `OTP_SETTLE_W'(`OTP_SETTLE_CYC);
        end else if (settle_cnt != '0) begin
            settle_cnt <= settle_cnt - 1'b1;
        end
    end

    // Secondary runs on request, in secondary mode, or on force unless digital input
    wire force_on      = ctrl2_reg[`OTP_C2_GO_BIT] && !secondary_digital_in;
    wire secondary_on  = secondary_request || force_on ||
                         (mode_reg == otp_pkg::OTP_MODE_SECOND);
    // Run flag follows the system clock source
    wire sys_on_second = (mode_reg == otp_pkg::OTP_MODE_SECOND);

    // Source select passed to the 31 kHz mux
    // Signed trim adds monotonically to nominal
    // Nominal 8.0 MHz with zero trim
    wire signed [6:0] trim_s = {trim_reg[`OTP_TRIM_MSB], trim_reg[`OTP_TRIM_MSB:`OTP_TRIM_LSB]};
    wire signed [14:0] freq_s = 15'sd`OTP_NOMINAL_KHZ + 15'(trim_s) * 15'sd40;

    // Registered control outputs
    // Registered so the analog side sees glitch-free controls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_ctrl     <= '0;
            slow_rc_trim <= '0;
            fast_osc_khz <= 14'(`OTP_NOMINAL_KHZ);
        end else begin
            osc_ctrl.fast_trim              <= trim_reg[`OTP_TRIM_MSB:`OTP_TRIM_LSB];
            osc_ctrl.low_freq_source_select <= trim_reg[`OTP_TRIM_SRC_BIT];
            osc_ctrl.pll_enable             <= pll_request;
            osc_ctrl.core_on_pll            <= (next_clk_state == otp_pkg::OTP_CLK_ON_PLL);
            osc_ctrl.secondary_run          <= secondary_on;
            slow_rc_trim                    <= '0;
            fast_osc_khz                    <= freq_s[13:0];
        end
    end

    // Read data mux
    // Only byte lane 0 carries data; upper lanes read as zero
    wire [7:0] ctrl2_view  = (ctrl2_reg & `OTP_C2_WMASK) | (8'(sys_on_second) << `OTP_C2_RUN_BIT);
    wire [7:0] status_view = (8'(pll_request)                           << `OTP_ST_PLLON_BIT)  |
                             (8'(pll_locked)                            << `OTP_ST_LOCK_BIT)   |
                             (8'(clk_state == otp_pkg::OTP_CLK_ON_PLL)  << `OTP_ST_ONPLL_BIT)  |
                             (8'(secondary_on)                          << `OTP_ST_SOSCON_BIT);
    wire [7:0] rd_byte =
        (s_axi_araddr == `OTP_ADDR_TRIM)   ? trim_reg :
        (s_axi_araddr == `OTP_ADDR_CTRL2)  ? ctrl2_view :
        (s_axi_araddr == `OTP_ADDR_MODE)   ? {6'h00, mode_reg} :
        (s_axi_araddr == `OTP_ADDR_STATUS) ? status_view : 8'h00;

    // Read response; unmapped reads answer SLVERR with zero data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `OTP_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= is_mapped(s_axi_araddr) ? `OTP_RESP_OKAY : `OTP_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // PLL never enabled outside multiplied mode
    pll_mode_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        osc_ctrl.pll_enable |-> $past(mode_reg) == otp_pkg::OTP_MODE_MULT)
        else $error("PLL enabled outside multiplied mode");

    no_early_switch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(clk_state == otp_pkg::OTP_CLK_ON_PLL) |-> $past(pll_locked))
        else $error("Core switched before PLL lock");

    // Lock while requested switches next cycle
    auto_switch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_state == otp_pkg::OTP_CLK_WAIT_LOCK && pll_locked && pll_request)
        |=> clk_state == otp_pkg::OTP_CLK_ON_PLL ##0 osc_ctrl.core_on_pll)
        else $error("Core did not switch after lock");

    // Trim write reaches the oscillator two cycles later
    trim_apply_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_trim |=> ##1 osc_ctrl.fast_trim == $past(w_data[5:0], 2))
        else $error("Trim not applied");

    force_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
        force_on |=> osc_ctrl.secondary_run)
        else $error("Secondary not running under force-on");

    // Run flag read back follows the clock source
    run_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && (s_axi_araddr == `OTP_ADDR_CTRL2)
        |=> s_axi_rdata[`OTP_C2_RUN_BIT] == ($past(mode_reg) == otp_pkg::OTP_MODE_SECOND))
        else $error("Run flag mismatch");

    slow_fixed_a: assert property (@(posedge aclk) disable iff (!aresetn)
        slow_rc_trim == '0)
        else $error("Slow RC trim moved");

    trim_mono_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ($signed(osc_ctrl.fast_trim) > $signed($past(osc_ctrl.fast_trim)))
        |-> fast_osc_khz > $past(fast_osc_khz))
        else $error("Trim not monotonic");

    // Source select follows the stored bit
    src_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> osc_ctrl.low_freq_source_select == $past(trim_reg[`OTP_TRIM_SRC_BIT]))
        else $error("Source select mismatch");

    // Trim write opens the settling window
    settle_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_trim |=> settle_cnt == `OTP_SETTLE_W'(`OTP_SETTLE_CYC))
        else $error("Settling window not loaded");

    read_while_settle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (settle_cnt != '0) && rd_fire |=> s_axi_rvalid)
        else $error("Read stalled during trim settling");

    // New PLL request keeps the current clock
    pll_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(pll_request) |=> !osc_ctrl.core_on_pll)
        else $error("Core switched as soon as PLL was requested");

    // Force-on ignored for a digital clock input
    digital_input_a: assert property (@(posedge aclk) disable iff (!aresetn)
        secondary_digital_in && !secondary_request && (mode_reg != otp_pkg::OTP_MODE_SECOND)
        |=> !osc_ctrl.secondary_run)
        else $error("Secondary forced on with a digital input");

    nominal_freq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> fast_osc_khz == 14'(`OTP_NOMINAL_KHZ))
        else $error("Untrimmed frequency not nominal");

    trim_mono_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ($signed(osc_ctrl.fast_trim) < $signed($past(osc_ctrl.fast_trim)))
        |-> fast_osc_khz < $past(fast_osc_khz))
        else $error("Trim not monotonic downward");

endmodule : otp_osc_ctrl

// File: verification/otp_osc_ctrl_bench.sv
`include "otp_osc_map.svh"

module otp_osc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // One expected bus answer: read flag, response code, read data
    typedef struct packed {
        logic        rd;
        logic [1:0]  resp;
        logic [31:0] data;
    } otp_note_t;

    logic                   aclk = 1'b0;
    logic                   aresetn = 1'b0;
    logic [13:0]            s_axi_awaddr = 14'h0000;
    logic                   s_axi_awvalid = 1'b0;
    logic                   s_axi_awready;
    logic [31:0]            s_axi_wdata = 32'h0;
    logic [3:0]             s_axi_wstrb = 4'h0;
    logic                   s_axi_wvalid = 1'b0;
    logic                   s_axi_wready;
    logic [1:0]             s_axi_bresp;
    logic                   s_axi_bvalid;
    logic                   s_axi_bready = 1'b0;
    logic [13:0]            s_axi_araddr = 14'h0000;
    logic                   s_axi_arvalid = 1'b0;
    logic                   s_axi_arready;
    logic [31:0]            s_axi_rdata;
    logic [1:0]             s_axi_rresp;
    logic                   s_axi_rvalid;
    logic                   s_axi_rready = 1'b0;
    logic                   pll_locked = 1'b0;
    logic                   secondary_request = 1'b0;
    logic                   secondary_digital_in = 1'b0;
    otp_pkg::otp_osc_ctrl_t osc_ctrl;
    logic [5:0]             slow_rc_trim;
    logic [13:0]            fast_osc_khz;
    otp_note_t              exp_q[$];
    int                     errors = 0;
    int                     n_tests = 0;
    int                     modes[4] = '{0, 1, 3, 2};

    // Free-running 125 MHz clock
    always #4 aclk = ~aclk;

    otp_osc_ctrl otp_osc_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pll_locked(pll_locked),
        .secondary_request(secondary_request), .secondary_digital_in(secondary_digital_in),
        .osc_ctrl(osc_ctrl), .slow_rc_trim(slow_rc_trim), .fast_osc_khz(fast_osc_khz));

    task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge aclk);
    endtask : step

    task automatic give_verdict;
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // Monitor: every accepted answer retires the oldest note
    always @(posedge aclk) begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
            chk({2'b0, s_axi_bresp, 32'h0}, {1'b0, exp_q.pop_front()}, "write answer");
        end
        if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
            chk({2'b01, s_axi_rresp, s_axi_rdata}, {1'b0, exp_q.pop_front()}, "read answer");
        end
    end

    // Write: both halves offered together, each dropped once taken
    // Each wait ends only on the answer; the watchdog bounds every wait
    task automatic axi_write(input logic [13:0] a, input logic [7:0] d, input logic [3:0] s,
                             input logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        exp_q.push_back({1'b0, r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_write

    task automatic axi_read(input logic [13:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_q.push_back({1'b1, r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) begin
                s_axi_arvalid <= 1'b0;
            end
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_read

    // Watchdog sized well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        $display("mismatch at %0t: timeout", $time);
        give_verdict();
    end

    initial begin
        logic [7:0] tv;
        logic [5:0] pt;
        int         pk;
        int         ek;
        void'($urandom(76477));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({22'h0, fast_osc_khz}, 36'd8000, "untrimmed khz");
        chk({26'h0, osc_ctrl}, 36'h0, "control after reset");
        axi_read(`OTP_ADDR_TRIM, 32'h0, `OTP_RESP_OKAY);
        axi_read(`OTP_ADDR_CTRL2, 32'h14, `OTP_RESP_OKAY);
        axi_read(14'h0000, 32'h0, `OTP_RESP_SLVERR);
        axi_write(14'h0004, 8'hff, 4'h1, `OTP_RESP_SLVERR);
        // Random trims; settle runs unseen while the bus still answers
        pt = 6'h00;
        pk = 8000;
        for (int i = 0; i < 8; i++) begin
            tv = 8'($urandom) & 8'hbf;
            ek = 8000 + 40 * int'($signed(tv[5:0]));
            axi_write(`OTP_ADDR_TRIM, tv, 4'h1, `OTP_RESP_OKAY);
            axi_read(`OTP_ADDR_STATUS, 32'h0, `OTP_RESP_OKAY);
            step(2);
            chk({22'h0, fast_osc_khz}, 36'(ek), "trimmed khz");
            chk({30'h0, osc_ctrl.fast_trim}, {30'h0, tv[5:0]}, "trim out");
            chk({35'h0, osc_ctrl.low_freq_source_select}, {35'h0, tv[7]}, "source select");
            chk({30'h0, slow_rc_trim}, 36'h0, "slow rc untouched");
            chk({35'h0, ($signed(tv[5:0]) > $signed(pt)) == (int'(fast_osc_khz) > pk)}, 36'h1, "direction");
            pt = tv[5:0];
            pk = ek;
        end
        axi_write(`OTP_ADDR_TRIM, 8'h15, 4'h0, `OTP_RESP_OKAY);
        axi_read(`OTP_ADDR_TRIM, {24'h0, tv}, `OTP_RESP_OKAY);
        // PLL request in every mode, multiplied mode last
        for (int i = 0; i < 4; i++) begin
            axi_write(`OTP_ADDR_MODE, 8'(modes[i]), 4'h1, `OTP_RESP_OKAY);
            axi_write(`OTP_ADDR_TRIM, 8'h40, 4'h1, `OTP_RESP_OKAY);
            step(6);
            chk({35'h0, osc_ctrl.pll_enable}, {35'h0, modes[i] == 2}, "pll gate");
            chk({35'h0, osc_ctrl.core_on_pll}, 36'h0, "no early switch");
        end
        pll_locked <= 1'b1;
        step(3);
        chk({35'h0, osc_ctrl.core_on_pll}, 36'h1, "switch on lock");
        axi_read(`OTP_ADDR_STATUS, 32'h7, `OTP_RESP_OKAY);
        axi_write(`OTP_ADDR_TRIM, 8'h00, 4'h1, `OTP_RESP_OKAY);
        step(2);
        chk({34'h0, osc_ctrl.pll_enable, osc_ctrl.core_on_pll}, 36'h0, "pll released");
        pll_locked <= 1'b0;
        // Force-on against request and digital input
        for (int i = 0; i < 8; i++) begin
            if (i[1:0] == 2'b00) begin
                axi_write(`OTP_ADDR_CTRL2, 8'h14 | {4'h0, i[2], 3'h0}, 4'h1, `OTP_RESP_OKAY);
            end
            secondary_request <= i[0];
            secondary_digital_in <= i[1];
            step(3);
            chk({35'h0, osc_ctrl.secondary_run}, {35'h0, i[0] | (i[2] & ~i[1])}, "force on");
        end
        secondary_request <= 1'b0;
        // Run flag ignores writes and follows the mode
        axi_write(`OTP_ADDR_MODE, 8'h00, 4'h1, `OTP_RESP_OKAY);
        axi_write(`OTP_ADDR_CTRL2, 8'hff, 4'h1, `OTP_RESP_OKAY);
        axi_read(`OTP_ADDR_CTRL2, 32'h1c, `OTP_RESP_OKAY);
        axi_write(`OTP_ADDR_MODE, 8'h03, 4'h1, `OTP_RESP_OKAY);
        axi_read(`OTP_ADDR_CTRL2, 32'h5c, `OTP_RESP_OKAY);
        step(4);
        give_verdict();
    end

endmodule : otp_osc_ctrl_bench
